// ===== hw/esm_pkg.sv
// constants and carriers of the extended serial mode control block
// assumes a 32-bit apb bus and byte addresses on paddr
package esm_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_PLO = 8'h08;
  localparam logic [7:0] ADDR_PHI = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;
  localparam int CTRL_ENA_BIT = 4;
  localparam int CTRL_RXSTOP_BIT = 3;
  localparam int CTRL_MANCH_BIT = 1;
  localparam int CTRL_ORDER_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h1B;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [3:0] RXS_16OR17 = 4'hE;
  localparam logic [4:0] CHAR_BITS_STD = 5'h09;
  localparam logic [4:0] CHAR_BITS_EXT = 5'h11;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FEM = 1;
  localparam int IRQ_OVR = 2;

  typedef struct packed {
    logic done;
    logic manch_err;
    logic len17;
    logic [1:0] stop_vals;
    logic overrun;
    logic parity_err;
    logic frame_err;
    logic buffer_read;
  } esm_rx_s;

  typedef struct packed {
    logic ext_mode;
    logic manchester_active;
    logic mode_reserved;
    logic msb_first;
    logic [1:0] rx_stop_count;
    logic [1:0] tx_stop_count;
    logic [4:0] max_char_bits;
    logic overrun_err;
    logic parity_err;
    logic frame_err;
  } esm_cfg_s;
endpackage

// ===== hw/esm_ctrl.sv
// extended serial mode control: apb registers, mode decode, rx status
// assumes receiver events arrive as one-cycle pulses on mclk
//
// Behaviour
// - bit 4 selects extended mode, else standard
// - receiver stop count one or two
// - transmit stop count from standard select
// - bit 1 selects manchester coding
// - mode table: 9 or 17 bits, reserved combo
// - bit 0 selects msb first order
// - manchester framing error held until buffer read or the next manchester frame
// - length flag 16 versus 17 bits
// - stop bit values updated only in manchester
// - 16-bit bit period register, two bytes, reset zero
// - code 1110 accepts 16 or 17 bits
// - manchester reports only overrun and framing error
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module esm_ctrl
  import esm_pkg::*;
#(
  parameter int PERIOD_W = 16
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic synchronous_select,
  input wire logic transmit_stop_count_select,
  input wire logic [3:0] rx_size_code,
  input esm_rx_s rx,
  output esm_cfg_s cfg,
  output logic [PERIOD_W-1:0] manchester_bit_period,
  output logic irq
);

  // elaboration check: the period register is fixed at 16 bits
  if (PERIOD_W != 16)
    $error("esm_ctrl: PERIOD_W must be 16");

  typedef struct packed {
    logic [7:0] ctrl;
    logic manchester_frame_error;
    logic len17;
    logic [1:0] stop_vals;
    logic [15:0] period;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic [31:0] rdata;
    logic rerr;
  } esm_state_s;

  esm_state_s s_r;
  esm_state_s s_nxt;
  logic wr_en;
  logic setup;
  logic [IRQ_W-1:0] ev;
  logic manch;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_PLO) ||
              (a == ADDR_PHI) || (a == ADDR_ISTAT) || (a == ADDR_IMASK);
  endfunction

  function automatic logic [31:0] rd_val(input logic [7:0] a,
                                         input esm_state_s s);
    rd_val = 32'h0000_0000;
    if (a == ADDR_CTRL)
      rd_val = {24'h00_0000, s.ctrl};
    else if (a == ADDR_STAT)
      rd_val = {28'h000_0000, s.manchester_frame_error, s.len17, s.stop_vals};
    else if (a == ADDR_PLO)
      rd_val = {24'h00_0000, s.period[7:0]};
    else if (a == ADDR_PHI)
      rd_val = {24'h00_0000, s.period[15:8]};
    else if (a == ADDR_ISTAT)
      rd_val = {29'h0000_0000, s.istat};
    else if (a == ADDR_IMASK)
      rd_val = {29'h0000_0000, s.imask};
  endfunction

  assign pready = 1'b1;
  assign prdata = s_r.rdata;
  assign pslverr = s_r.rerr;
  assign wr_en = psel && penable && pwrite;
  assign setup = psel && !penable;

  assign cfg.ext_mode = s_r.ctrl[CTRL_ENA_BIT];
  assign cfg.mode_reserved = cfg.ext_mode && synchronous_select &&
                             s_r.ctrl[CTRL_MANCH_BIT];
  assign manch = cfg.ext_mode && s_r.ctrl[CTRL_MANCH_BIT] &&
                 !synchronous_select;
  assign cfg.manchester_active = manch;
  assign cfg.msb_first = cfg.ext_mode && s_r.ctrl[CTRL_ORDER_BIT];
  assign cfg.rx_stop_count = (cfg.ext_mode && s_r.ctrl[CTRL_RXSTOP_BIT]) ?
                             STOP_TWO : STOP_ONE;
  assign cfg.tx_stop_count = transmit_stop_count_select ? STOP_TWO :
                             STOP_ONE;
  assign cfg.max_char_bits = cfg.ext_mode ? CHAR_BITS_EXT : CHAR_BITS_STD;
  assign cfg.overrun_err = rx.overrun;
  assign cfg.parity_err = rx.parity_err && !manch;
  assign cfg.frame_err = rx.frame_err && !manch;
  assign manchester_bit_period = s_r.period;
  assign irq = |(s_r.istat & s_r.imask);

  always_comb
  begin
    s_nxt = s_r;
    ev = '0;
    ev[IRQ_DONE] = rx.done;
    ev[IRQ_FEM] = rx.done && manch && rx.manch_err;
    ev[IRQ_OVR] = rx.overrun;
    if (setup)
    begin
      s_nxt.rdata = rd_val(paddr, s_r);
      s_nxt.rerr = !addr_ok(paddr);
    end
    if (wr_en)
    begin
      if (paddr == ADDR_CTRL)
        s_nxt.ctrl = pwdata[7:0] & CTRL_WMASK;
      else if (paddr == ADDR_PLO)
        s_nxt.period[7:0] = pwdata[7:0];
      else if (paddr == ADDR_PHI)
        s_nxt.period[15:8] = pwdata[7:0];
      else if (paddr == ADDR_ISTAT)
        s_nxt.istat = s_r.istat & ~pwdata[IRQ_W-1:0];
      else if (paddr == ADDR_IMASK)
        s_nxt.imask = pwdata[IRQ_W-1:0];
    end
    // framing flag cleared by buffer read
    if (rx.buffer_read)
    begin
      s_nxt.manchester_frame_error = 1'b0;
      s_nxt.len17 = 1'b0;
    end
    if (rx.done && manch)
    begin
      s_nxt.manchester_frame_error = rx.manch_err;
      s_nxt.len17 = (rx_size_code == RXS_16OR17) && rx.len17;
      s_nxt.stop_vals = rx.stop_vals;
    end
    s_nxt.istat = s_nxt.istat | ev;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r.ctrl <= CTRL_RESET;
      s_r.manchester_frame_error <= 1'b0;
      s_r.len17 <= 1'b0;
      s_r.stop_vals <= 2'h0;
      s_r.period <= PERIOD_RESET;
      s_r.istat <= '0;
      s_r.imask <= '0;
      s_r.rdata <= 32'h0000_0000;
      s_r.rerr <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  property p_std_len;
    @(posedge mclk) disable iff (rst)
    !s_r.ctrl[CTRL_ENA_BIT] |-> cfg.max_char_bits == CHAR_BITS_STD &&
      !cfg.manchester_active && !cfg.msb_first;
  endproperty
  a_std_len: assert property (p_std_len)
    else $error("standard mode shows extended behaviour");

  property p_rx_stop;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_CTRL) |=>
      cfg.rx_stop_count == (($past(pwdata[CTRL_RXSTOP_BIT]) &&
        $past(pwdata[CTRL_ENA_BIT])) ? STOP_TWO : STOP_ONE);
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("receiver stop count wrong");

  property p_tx_stop;
    @(posedge mclk) disable iff (rst)
    cfg.tx_stop_count == (transmit_stop_count_select ? STOP_TWO : STOP_ONE);
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("transmit stop count not from standard select");

  property p_manch;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_ENA_BIT] &&
     pwdata[CTRL_MANCH_BIT]) ##1 !synchronous_select |->
      cfg.manchester_active && !cfg.mode_reserved;
  endproperty
  a_manch: assert property (p_manch)
    else $error("manchester not active after enable");

  property p_order;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_CTRL) |=>
      cfg.msb_first == ($past(pwdata[CTRL_ORDER_BIT]) &&
        $past(pwdata[CTRL_ENA_BIT]));
  endproperty
  a_order: assert property (p_order)
    else $error("bit order does not follow control write");

  property p_fem_set;
    @(posedge mclk) disable iff (rst)
    (rx.done && manch && rx.manch_err) |=> s_r.manchester_frame_error && s_r.istat[IRQ_FEM];
  endproperty
  a_fem_set: assert property (p_fem_set)
    else $error("manchester framing error not captured");

  property p_fem_clr;
    @(posedge mclk) disable iff (rst)
    (rx.buffer_read && !rx.done) |=> !s_r.manchester_frame_error && !s_r.len17;
  endproperty
  a_fem_clr: assert property (p_fem_clr)
    else $error("status not cleared by buffer read");

  property p_len;
    @(posedge mclk) disable iff (rst)
    (rx.done && manch && rx_size_code == RXS_16OR17) |=>
      s_r.len17 == $past(rx.len17);
  endproperty
  a_len: assert property (p_len)
    else $error("length flag does not match frame");

  property p_stop_hold;
    @(posedge mclk) disable iff (rst)
    !manch |=> $stable(s_r.stop_vals);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop values changed in level mode");

  property p_period;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_PHI) |=>
      manchester_bit_period[15:8] == $past(pwdata[7:0]) &&
      $stable(manchester_bit_period[7:0]);
  endproperty
  a_period: assert property (p_period)
    else $error("bit period high byte not written");

  property p_errs;
    @(posedge mclk) disable iff (rst)
    manch |-> !cfg.parity_err && !cfg.frame_err &&
      cfg.overrun_err == rx.overrun;
  endproperty
  a_errs: assert property (p_errs)
    else $error("level errors reported in manchester mode");

  property p_irq;
    @(posedge mclk) disable iff (rst)
    (rx.done && s_r.imask[IRQ_DONE] && !wr_en) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked event gave no interrupt");

  property p_ctrl_resv;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_CTRL) |=>
      (s_r.ctrl & ~CTRL_WMASK) == 8'h00;
  endproperty
  a_ctrl_resv: assert property (p_ctrl_resv)
    else $error("reserved control bits not zero");

  property p_stat_ro;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_STAT && !rx.done && !rx.buffer_read) |=>
      $stable({s_r.manchester_frame_error, s_r.len17, s_r.stop_vals});
  endproperty
  a_stat_ro: assert property (p_stat_ro)
    else $error("status changed by a software write");

  property p_len_code;
    @(posedge mclk) disable iff (rst)
    (rx.done && manch && rx_size_code != RXS_16OR17) |=> !s_r.len17;
  endproperty
  a_len_code: assert property (p_len_code)
    else $error("length flag set outside 16-or-17 code");

  property p_w1c;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_ISTAT && rx.done) |=>
      s_r.istat[IRQ_DONE];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("interrupt event lost to a clear");

  property p_period_lo;
    @(posedge mclk) disable iff (rst)
    (wr_en && paddr == ADDR_PLO) |=>
      manchester_bit_period[7:0] == $past(pwdata[7:0]) &&
      $stable(manchester_bit_period[15:8]);
  endproperty
  a_period_lo: assert property (p_period_lo)
    else $error("bit period low byte not written");

  property p_mode_resv;
    @(posedge mclk) disable iff (rst)
    cfg.mode_reserved |-> !cfg.manchester_active && cfg.ext_mode;
  endproperty
  a_mode_resv: assert property (p_mode_resv)
    else $error("reserved mode runs manchester");

  property p_err_resp;
    @(posedge mclk) disable iff (rst)
    (psel && penable && !addr_ok(paddr)) |->
      pslverr && prdata == 32'h0000_0000;
  endproperty
  a_err_resp: assert property (p_err_resp)
    else $error("unmapped access without error response");

  property p_stop_upd;
    @(posedge mclk) disable iff (rst)
    (rx.done && manch) |=>
      s_r.stop_vals == $past(rx.stop_vals);
  endproperty
  a_stop_upd: assert property (p_stop_upd)
    else $error("stop values not captured in manchester");

  c_manch_frame: cover property (@(posedge mclk) disable iff (rst)
    rx.done && manch);
  c_fem: cover property (@(posedge mclk) disable iff (rst)
    rx.done && manch && rx.manch_err ##[1:20] rx.buffer_read);
  c_irq: cover property (@(posedge mclk) disable iff (rst) $rose(irq));
  c_len17: cover property (@(posedge mclk) disable iff (rst)
    rx.done && manch && rx.len17 && rx_size_code == RXS_16OR17);
  c_period: cover property (@(posedge mclk) disable iff (rst)
    wr_en && paddr == ADDR_PLO);
endmodule

// ===== testbench/esm_rx_model.sv
// receiver event source standing in for the remote transceiver
// assumes the block samples manch_err, len17 and stop_vals only together with done
`timescale 1ns/1ps
module esm_rx_model
  import esm_pkg::*;
(
  input wire logic mclk,
  output esm_rx_s rx
);
  initial rx = '0;

  task automatic frame(input logic me, input logic l17,
                       input logic [1:0] sv);
    @(posedge mclk);
    rx.done <= 1'b1;
    {rx.manch_err, rx.len17, rx.stop_vals} <= {me, l17, sv};
    @(posedge mclk);
    rx.done <= 1'b0;
    // stale fields no longer valid
    {rx.manch_err, rx.len17, rx.stop_vals} <= ~{me, l17, sv};
  endtask

  task automatic read_buf;
    @(posedge mclk);
    rx.buffer_read <= 1'b1;
    @(posedge mclk);
    rx.buffer_read <= 1'b0;
  endtask

  task automatic errs(input logic [2:0] e);
    @(posedge mclk);
    {rx.overrun, rx.parity_err, rx.frame_err} <= e;
  endtask
endmodule

// ===== testbench/extended_serial_mode_control_tb.sv
// self-checking bench of the serial mode control registers
// assumes the apb slave and the rx event model above
`timescale 1ns/1ps
module extended_serial_mode_control_tb
  import esm_pkg::*;
;
  typedef struct packed {
    logic [7:0] wr;
    logic sy;
    logic ts;
    logic [7:0] rd;
    esm_cfg_s c;
  } esm_row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sync_sel = 1'b0;
  logic tx_stop = 1'b0;
  logic [3:0] size_code = 4'h0;
  esm_rx_s rx;
  esm_cfg_s cfg;
  logic [15:0] period;
  logic irq;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int check_count = 0;
  esm_row_s rows[4] = '{
    {8'h1B, 2'h0, 8'h1B, 4'hD, STOP_TWO, STOP_ONE, CHAR_BITS_EXT, 3'h0},
    {8'h1B, 2'h3, 8'h1B, 4'hB, STOP_TWO, STOP_TWO, CHAR_BITS_EXT, 3'h0},
    {8'h0B, 2'h1, 8'h0B, 4'h0, STOP_ONE, STOP_TWO, CHAR_BITS_STD, 3'h0},
    {8'h10, 2'h2, 8'h10, 4'h8, STOP_ONE, STOP_ONE, CHAR_BITS_EXT, 3'h0}};
  logic [7:0] regs[6] = '{ADDR_CTRL, ADDR_STAT, ADDR_PLO, ADDR_PHI,
                          ADDR_ISTAT, ADDR_IMASK};

  always #20 mclk = ~mclk;

  esm_ctrl u_dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .synchronous_select(sync_sel),
    .transmit_stop_count_select(tx_stop), .rx_size_code(size_code),
    .rx(rx), .cfg(cfg), .manchester_bit_period(period), .irq(irq));
  esm_rx_model u_rx (.mclk(mclk), .rx(rx));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      sync_sel <= rows[i].sy;
      tx_stop <= rows[i].ts;
      apb(1'b1, ADDR_CTRL, {24'h0, rows[i].wr});
      rdc(ADDR_CTRL, {24'h0, rows[i].rd});
      chk({16'h0, cfg}, {16'h0, rows[i].c});
    end
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (regs[i])
      rdc(regs[i], 32'h0);
    apb(1'b1, ADDR_PLO, 32'hA5);
    apb(1'b1, ADDR_PHI, 32'h3C);
    @(negedge mclk);
    chk({16'h0, period}, 32'h3CA5);
    rdc(ADDR_PHI, 32'h3C);
    rdc(8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    // status is read-only: a write of ones to its bits leaves them zero
    apb(1'b1, ADDR_STAT, 32'h0F);
    rdc(ADDR_STAT, 32'h0);
    sync_sel <= 1'b0;
    size_code <= RXS_16OR17;
    apb(1'b1, ADDR_CTRL, 32'h12);
    apb(1'b1, ADDR_IMASK, 32'h3);
    u_rx.frame(1'b1, 1'b1, 2'h2);
    rdc(ADDR_STAT, 32'h0E);
    rdc(ADDR_ISTAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    u_rx.read_buf();
    rdc(ADDR_STAT, 32'h02);
    apb(1'b1, ADDR_ISTAT, 32'h3);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    size_code <= 4'hF;
    u_rx.frame(1'b0, 1'b1, 2'h1);
    rdc(ADDR_STAT, 32'h01);
    apb(1'b1, ADDR_ISTAT, 32'h7);
    apb(1'b1, ADDR_IMASK, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h10);
    u_rx.frame(1'b1, 1'b1, 2'h2);
    rdc(ADDR_STAT, 32'h01);
    rdc(ADDR_ISTAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    u_rx.errs(3'h7);
    repeat (2) @(negedge mclk);
    chk({29'h0, cfg[2:0]}, 32'h7);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h12);
    @(negedge mclk);
    chk({29'h0, cfg[2:0]}, 32'h4);
    u_rx.errs(3'h0);
    apb(1'b1, ADDR_ISTAT, 32'h7);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    // event and clear in one cycle: set wins
    fork
      apb(1'b1, ADDR_ISTAT, 32'h1);
      begin
        @(posedge mclk);
        u_rx.frame(1'b0, 1'b0, 2'h0);
      end
    join
    rdc(ADDR_ISTAT, 32'h1);
    conclude();
  end
endmodule
